// >>> hdl/drtc_consts.vh
// constants for the dual reload timer control block
`ifndef DRTC_CONSTS_VH
`define DRTC_CONSTS_VH
`define DRTC_CNT_W        16
`define DRTC_ADDR_W       4
`define DRTC_DIV          20
`define DRTC_DIV_W        5
`define DRTC_A_CTRL       4'h0
`define DRTC_A_C0_LO      4'h1
`define DRTC_A_C0_HI      4'h2
`define DRTC_A_C1_LO      4'h3
`define DRTC_A_C1_HI      4'h4
`define DRTC_A_R0_LO      4'h5
`define DRTC_A_R0_HI      4'h6
`define DRTC_A_R1_LO      4'h7
`define DRTC_A_R1_HI      4'h8
`define DRTC_A_IRQ_STAT   4'h9
`define DRTC_A_IRQ_MASK   4'hA
`define DRTC_B_FLAG1      7
`define DRTC_B_FLAG0      6
`define DRTC_B_IE1        5
`define DRTC_B_IE0        4
`define DRTC_B_OC_HI      3
`define DRTC_B_OC_LO      2
`define DRTC_B_CE1        1
`define DRTC_B_CE0        0
`define DRTC_OC_ADDR      2'b00
`define DRTC_OC_TOGGLE    2'b01
`define DRTC_OC_LOW       2'b10
`define DRTC_OC_HIGH      2'b11
`define DRTC_CTRL_RST     8'h00
`endif

// >>> hdl/drtc_chan.v
// one reload down-counter channel
`timescale 1ns/1ns
module drtc_chan #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  input  wire         tick,
  input  wire         cnt_en,
  input  wire         wr_lo,
  input  wire         wr_hi,
  input  wire         rl_wr_lo,
  input  wire         rl_wr_hi,
  input  wire [7:0]   wdata,
  output reg  [W-1:0] count_reg,
  output reg  [W-1:0] reload_reg,
  output reg          zero_pulse
);
  reg          at_zero_reg;

  always @(posedge clk) begin
    if (rst) begin
      count_reg   <= {W{1'b1}};
      reload_reg  <= {W{1'b1}};
      at_zero_reg <= 1'b0;
      zero_pulse  <= 1'b0;
    end else if (ce) begin
      zero_pulse <= 1'b0;
      if (rl_wr_lo)
        reload_reg[7:0] <= wdata;
      if (rl_wr_hi)
        reload_reg[W-1:8] <= wdata[W-9:0];
      if (!cnt_en) begin
        at_zero_reg <= 1'b0;
        if (wr_lo)
          count_reg[7:0] <= wdata;
        if (wr_hi)
          count_reg[W-1:8] <= wdata[W-9:0];
      end else if (tick) begin // RULE7 RULE11
        if (at_zero_reg) begin
          count_reg   <= reload_reg; // RULE12
          at_zero_reg <= 1'b0;
        end else if (count_reg == {{(W-1){1'b0}}, 1'b1}) begin
          count_reg   <= {W{1'b0}};
          at_zero_reg <= 1'b1;
          zero_pulse  <= 1'b1; // RULE1
        end else if (count_reg == {W{1'b0}}) begin
          count_reg <= reload_reg;
        end else begin
          count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// >>> hdl/drtc_top.v
// dual reload timer control: register port, channels, flags, pin mux
// Function
// RULE1: a channel's zero flag sets whenever its counter decrements to zero
// RULE2: per channel interrupt request while flag and its enable are both one
// RULE3: flag clears after control read then read of that channel's counter
// RULE4: reset clears flags, interrupt enables and output select bits
// RULE5: output select zero makes the shared pin carry the address
// RULE6: timer function sets, clears or toggles pin at channel 1 zero
// RULE7: channel counts only while its count enable is one; else writable
// RULE8: reset clears count enables; no decrement until software sets them
// RULE9: control layout: flags 7-6, irq enables 5-4, select 3-2, enables 1-0
// RULE10: each channel holds 16-bit down counter and 16-bit reload register
// RULE11: counters advance only on system clock divided by 20
// RULE12: at zero the counter reloads on the next tick and continues
// RULE13: select 00 address, 01 toggle, 10 low, 11 high
`timescale 1ns/1ns
`include "drtc_consts.vh"
module drtc_top #(
  parameter CNT_W = `DRTC_CNT_W,
  parameter DIV   = `DRTC_DIV
) (
  input  wire       CLK_SYS,
  input  wire       RST,
  input  wire       CE,
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       ADDR_BIT_IN,
  output wire       SHARED_ADDR_TIMER_PIN,
  output wire       CHAN0_IRQ,
  output wire       CHAN1_IRQ,
  output wire       IRQ
);
  ////////////////////////////////////////////////////////////////////////
  // time base
  reg  [`DRTC_DIV_W-1:0] div_reg;
  wire                   tick;

  always @(posedge CLK_SYS) begin
    if (RST)
      div_reg <= {`DRTC_DIV_W{1'b0}};
    else if (CE) begin
      if (div_reg == DIV - 1) // RULE11
        div_reg <= {`DRTC_DIV_W{1'b0}};
      else
        div_reg <= div_reg + 1'b1;
    end
  end
  assign tick = (div_reg == DIV - 1);

  ////////////////////////////////////////////////////////////////////////
  // control register
  reg  [1:0] irq_en_reg;
  reg  [1:0] pin_output_select_reg;
  reg  [1:0] count_en_reg;
  reg  [1:0] flag_reg;
  reg  [1:0] armed_reg;
  reg  [1:0] stat_reg;
  reg  [1:0] mask_reg;
  wire       ctrl_wr;
  wire       ctrl_rd;
  wire [1:0] cnt_wr_lo;
  wire [1:0] cnt_wr_hi;
  wire [1:0] rl_wr_lo;
  wire [1:0] rl_wr_hi;
  wire [1:0] cnt_rd;
  wire [1:0] zero_pulse;
  wire [CNT_W-1:0] count0; // RULE10
  wire [CNT_W-1:0] count1;
  wire [CNT_W-1:0] reload0;
  wire [CNT_W-1:0] reload1;

  assign ctrl_wr = WR && (ADDR == `DRTC_A_CTRL);
  assign ctrl_rd = RD && (ADDR == `DRTC_A_CTRL);
  assign cnt_wr_lo = {WR && (ADDR == `DRTC_A_C1_LO),
                      WR && (ADDR == `DRTC_A_C0_LO)};
  assign cnt_wr_hi = {WR && (ADDR == `DRTC_A_C1_HI),
                      WR && (ADDR == `DRTC_A_C0_HI)};
  assign rl_wr_lo  = {WR && (ADDR == `DRTC_A_R1_LO),
                      WR && (ADDR == `DRTC_A_R0_LO)};
  assign rl_wr_hi  = {WR && (ADDR == `DRTC_A_R1_HI),
                      WR && (ADDR == `DRTC_A_R0_HI)};
  assign cnt_rd = {RD && (ADDR == `DRTC_A_C1_LO || ADDR == `DRTC_A_C1_HI),
                   RD && (ADDR == `DRTC_A_C0_LO || ADDR == `DRTC_A_C0_HI)};

  always @(posedge CLK_SYS) begin
    if (RST) begin
      irq_en_reg            <= 2'b00; // RULE4
      pin_output_select_reg <= 2'b00; // RULE4
      count_en_reg          <= 2'b00; // RULE8
      flag_reg              <= 2'b00; // RULE4
      armed_reg             <= 2'b00;
      mask_reg              <= 2'b00;
    end else if (CE) begin
      if (ctrl_wr) begin
        irq_en_reg            <= WDATA[`DRTC_B_IE1:`DRTC_B_IE0];
        pin_output_select_reg <= WDATA[`DRTC_B_OC_HI:`DRTC_B_OC_LO];
        count_en_reg          <= WDATA[`DRTC_B_CE1:`DRTC_B_CE0];
      end
      if (WR && ADDR == `DRTC_A_IRQ_MASK)
        mask_reg <= WDATA[1:0];
      // flag clears after a control read then counter read; set wins
      flag_reg  <= zero_pulse | (flag_reg & ~(armed_reg & cnt_rd)); // RULE1 RULE3
      armed_reg <= (ctrl_rd ? flag_reg : (armed_reg & ~cnt_rd)) & ~zero_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins
  always @(posedge CLK_SYS) begin
    if (RST)
      stat_reg <= 2'b00;
    else if (CE) begin
      if (WR && ADDR == `DRTC_A_IRQ_STAT)
        stat_reg <= zero_pulse | (stat_reg & ~WDATA[1:0]);
      else
        stat_reg <= zero_pulse | stat_reg;
    end
  end

  assign CHAN0_IRQ = flag_reg[0] & irq_en_reg[0]; // RULE2
  assign CHAN1_IRQ = flag_reg[1] & irq_en_reg[1]; // RULE2
  assign IRQ       = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////
  // channels
  drtc_chan #(.W(CNT_W)) u_chan0 (
    .clk        (CLK_SYS),
    .rst        (RST),
    .ce         (CE),
    .tick       (tick),
    .cnt_en     (count_en_reg[0]), // RULE7
    .wr_lo      (cnt_wr_lo[0]),
    .wr_hi      (cnt_wr_hi[0]),
    .rl_wr_lo   (rl_wr_lo[0]),
    .rl_wr_hi   (rl_wr_hi[0]),
    .wdata      (WDATA),
    .count_reg  (count0),
    .reload_reg (reload0),
    .zero_pulse (zero_pulse[0])
  );

  drtc_chan #(.W(CNT_W)) u_chan1 (
    .clk        (CLK_SYS),
    .rst        (RST),
    .ce         (CE),
    .tick       (tick),
    .cnt_en     (count_en_reg[1]), // RULE7
    .wr_lo      (cnt_wr_lo[1]),
    .wr_hi      (cnt_wr_hi[1]),
    .rl_wr_lo   (rl_wr_lo[1]),
    .rl_wr_hi   (rl_wr_hi[1]),
    .wdata      (WDATA),
    .count_reg  (count1),
    .reload_reg (reload1),
    .zero_pulse (zero_pulse[1])
  );

  ////////////////////////////////////////////////////////////////////////
  // shared pin
  reg  addr_s1_reg;
  reg  addr_s2_reg;
  reg  tout_reg;

  always @(posedge CLK_SYS) begin
    if (RST) begin
      addr_s1_reg <= 1'b0;
      addr_s2_reg <= 1'b0;
      tout_reg    <= 1'b0;
    end else if (CE) begin
      addr_s1_reg <= ADDR_BIT_IN;
      addr_s2_reg <= addr_s1_reg;
      if (zero_pulse[1]) begin
        case (pin_output_select_reg) // RULE6 RULE13
          `DRTC_OC_TOGGLE: tout_reg <= ~tout_reg;
          `DRTC_OC_LOW:    tout_reg <= 1'b0;
          `DRTC_OC_HIGH:   tout_reg <= 1'b1;
          default:         tout_reg <= tout_reg;
        endcase
      end
    end
  end

  assign SHARED_ADDR_TIMER_PIN =
    (pin_output_select_reg == `DRTC_OC_ADDR) ? addr_s2_reg : tout_reg; // RULE5

  ////////////////////////////////////////////////////////////////////////
  // read port
  always @(posedge CLK_SYS) begin
    if (RST)
      RDATA <= 8'h00;
    else if (CE) begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `DRTC_A_CTRL:     RDATA <= {flag_reg, irq_en_reg, // RULE9
                                      pin_output_select_reg, count_en_reg};
          `DRTC_A_C0_LO:    RDATA <= count0[7:0];
          `DRTC_A_C0_HI:    RDATA <= count0[CNT_W-1:8];
          `DRTC_A_C1_LO:    RDATA <= count1[7:0];
          `DRTC_A_C1_HI:    RDATA <= count1[CNT_W-1:8];
          `DRTC_A_R0_LO:    RDATA <= reload0[7:0];
          `DRTC_A_R0_HI:    RDATA <= reload0[CNT_W-1:8];
          `DRTC_A_R1_LO:    RDATA <= reload1[7:0];
          `DRTC_A_R1_HI:    RDATA <= reload1[CNT_W-1:8];
          `DRTC_A_IRQ_STAT: RDATA <= {6'h00, stat_reg};
          `DRTC_A_IRQ_MASK: RDATA <= {6'h00, mask_reg};
          default:          RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule

// >>> verification/drtc_asserts.sv
// assertion checker for the dual reload timer control block
`timescale 1ns/1ns
`include "drtc_consts.vh"
module drtc_asserts #(
  parameter CNT_W = 16,
  parameter DIV   = 20
) (
  input wire       CLK_SYS,
  input wire       RST,
  input wire       CE,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  input wire       ADDR_BIT_IN,
  input wire       SHARED_ADDR_TIMER_PIN,
  input wire       CHAN0_IRQ,
  input wire       CHAN1_IRQ,
  input wire       IRQ
);
  reg [5:0] ctl_reg;
  reg [1:0] msk_reg;
  always @(posedge CLK_SYS) begin
    if (RST) begin
      ctl_reg <= 6'h00;
      msk_reg <= 2'h0;
    end else if (CE && WR && ADDR == `DRTC_A_CTRL) begin
      ctl_reg <= WDATA[5:0];
    end else if (CE && WR && ADDR == `DRTC_A_IRQ_MASK) begin
      msk_reg <= WDATA[1:0];
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_ctl_rd;
    CE && RD && ADDR == `DRTC_A_CTRL;
  endsequence
  sequence s_ch1_idle;
    !ctl_reg[1] && !$past(ctl_reg[1]) && !$past(ctl_reg[1], 2)
      && !$past(ctl_reg[1], 3);
  endsequence
  AST_IRQ0: assert property (CHAN0_IRQ |-> ctl_reg[4])
    else $error("chan0 irq without enable");
  AST_IRQ1: assert property (CHAN1_IRQ |-> ctl_reg[5])
    else $error("chan1 irq without enable");
  AST_IRQ_OUT: assert property (IRQ |-> msk_reg != 2'h0)
    else $error("irq with all masked");
  AST_RD_IDLE: assert property (CE && !RD |=> RDATA == 8'h00)
    else $error("read data without read");
  AST_UNMAPPED: assert property (CE && RD && ADDR > `DRTC_A_IRQ_MASK
    |=> RDATA == 8'h00) else $error("unmapped read not zero");
  AST_CTRL_RD: assert property (s_ctl_rd |=> RDATA[5:0] == $past(ctl_reg))
    else $error("control read mismatch");
  AST_RESET: assert property ($fell(RST) |-> RDATA == 8'h00 && !IRQ
    && !CHAN0_IRQ && !CHAN1_IRQ) else $error("outputs after reset");
  AST_PIN_ADDR: assert property (ctl_reg[3:2] == 2'b00 && $past(CE)
    && $past(CE, 2) && !$past(RST) && !$past(RST, 2)
    |-> SHARED_ADDR_TIMER_PIN == $past(ADDR_BIT_IN, 2))
    else $error("pin not address");
  AST_PIN_HOLD: assert property (ctl_reg[3:2] != 2'b00
    && $stable(ctl_reg) ##0 s_ch1_idle |-> $stable(SHARED_ADDR_TIMER_PIN))
    else $error("pin moved while stopped");
endmodule
bind drtc_top drtc_asserts #(.CNT_W(CNT_W), .DIV(DIV)) drtc_asserts_i (
  .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .ADDR_BIT_IN(ADDR_BIT_IN),
  .SHARED_ADDR_TIMER_PIN(SHARED_ADDR_TIMER_PIN), .CHAN0_IRQ(CHAN0_IRQ),
  .CHAN1_IRQ(CHAN1_IRQ), .IRQ(IRQ));

// >>> verification/testbench.sv
// self-checking bench for the dual reload timer control block
`timescale 1ns/1ns
`include "drtc_consts.vh"
module testbench;
  localparam DIV = 4;
  reg        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, abit = 1'b0;
  reg  [3:0] addr = 4'h0;
  reg  [7:0] wdata = 8'h00, v;
  wire [7:0] rdata;
  wire       pin, irq0, irq1, irq;
  integer    errors = 0, n_compared = 0, i, j;
  drtc_top #(.DIV(DIV)) drtc_top_i (.CLK_SYS(clk), .RST(rst), .CE(1'b1),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .ADDR_BIT_IN(abit), .SHARED_ADDR_TIMER_PIN(pin), .CHAN0_IRQ(irq0),
    .CHAN1_IRQ(irq1), .IRQ(irq));
  initial forever #25 clk = ~clk;
  task stop_test;
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input [7:0] seen, input [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task load(input [3:0] a, input [7:0] d);
    wr_reg(a, d);
    wr_reg(a + 4'h1, 8'h00);
  endtask
  task rd_reg(input [3:0] a, output [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task wait_for(input integer w, input b);
    for (i = 0; i < 99 && (w ? pin : irq0) !== b; i = i + 1) begin
      @(posedge clk);
      #1;
    end
    if (i == 99) begin
      errors = errors + 1;
      stop_test;
    end
  endtask
  task t_reset;
    rd_reg(`DRTC_A_CTRL, v);
    check(v, `DRTC_CTRL_RST);
    rd_reg(`DRTC_A_C0_LO, v);
    check(v, 8'hFF);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, v);
    check(v, 8'h00);
    rd_reg(`DRTC_A_C1_LO, v);
    check(v, 8'hFF);
  endtask
  task t_chan0;
    load(`DRTC_A_R0_LO, 8'h02);
    load(`DRTC_A_C0_LO, 8'h02);
    rd_reg(`DRTC_A_C0_LO, v);
    check(v, 8'h02);
    wr_reg(`DRTC_A_CTRL, 8'h11);
    wait_for(0, 1'b1);
    check({7'h00, i >= DIV + 1 && i <= 2 * DIV + 3}, 8'h01);
    wr_reg(`DRTC_A_CTRL, 8'h10);
    check({7'h00, irq}, 8'h00);
    rd_reg(`DRTC_A_C0_LO, v);
    check({7'h00, irq0}, 8'h01);
    rd_reg(`DRTC_A_CTRL, v);
    check(v, 8'h50);
    rd_reg(`DRTC_A_C0_HI, v);
    check({7'h00, irq0}, 8'h00);
    rd_reg(`DRTC_A_IRQ_STAT, v);
    check(v, 8'h01);
    wr_reg(`DRTC_A_IRQ_MASK, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr_reg(`DRTC_A_IRQ_STAT, 8'h01);
    check({7'h00, irq}, 8'h00);
  endtask
  task t_pin;
    load(`DRTC_A_R1_LO, 8'h03);
    load(`DRTC_A_C1_LO, 8'h03);
    wr_reg(`DRTC_A_CTRL, {4'h0, `DRTC_OC_HIGH, 2'b10});
    wait_for(1, 1'b1);
    rd_reg(`DRTC_A_CTRL, v);
    check(v, 8'h8E);
    check({7'h00, irq1}, 8'h00);
    wr_reg(`DRTC_A_CTRL, {4'h0, `DRTC_OC_LOW, 2'b10});
    wait_for(1, 1'b0);
    wr_reg(`DRTC_A_CTRL, {4'h0, `DRTC_OC_TOGGLE, 2'b10});
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    wr_reg(`DRTC_A_CTRL, {4'h0, `DRTC_OC_HIGH, 2'b00});
    repeat (5 * DIV) @(posedge clk);
    #1;
    check({7'h00, pin}, 8'h00);
    wr_reg(`DRTC_A_CTRL, 8'h00);
    for (j = 0; j < 2; j = j + 1) begin
      @(posedge clk);
      abit <= ~j[0];
      repeat (3) @(posedge clk);
      #1;
      check({7'h00, pin}, {7'h00, ~j[0]});
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_chan0;
    t_pin;
    stop_test;
  end
endmodule
